// file: ctrb_consts.svh
// Purpose: Constants for the converter trim register bank
// Assumes: Included by the package and both design modules
// Notes:   Indices are register numbers; byte address is index times four
`ifndef CTRB_CONSTS_SVH
`define CTRB_CONSTS_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define CTRB_ADDR_W 12
`define CTRB_DATA_W 32
`define CTRB_BE_W 4
`define CTRB_IDX_W 10
`define CTRB_NUM_REGS 9
`define CTRB_NUM_BANKS 4

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define CTRB_IDX_B_OFS 10'h34E
`define CTRB_IDX_DUAL_A0 10'h350
`define CTRB_IDX_DUAL_A1 10'h351
`define CTRB_IDX_DUAL_B0 10'h352
`define CTRB_IDX_DUAL_B1 10'h353
`define CTRB_IDX_SNGL_A0 10'h354
`define CTRB_IDX_SNGL_A1 10'h355
`define CTRB_IDX_SNGL_B0 10'h356
`define CTRB_IDX_SNGL_B1 10'h357
`define CTRB_IDX_STATUS 10'h3F0

// ----------------------------------------------------------------------
// Slots in the register array
// ----------------------------------------------------------------------
`define CTRB_SLOT_B_OFS 0
`define CTRB_SLOT_DUAL0 1
`define CTRB_SLOT_SNGL0 5

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define CTRB_OFS_MSB 11
`define CTRB_OFS_W 12
`define CTRB_GAIN_MSB 4
`define CTRB_GAIN_W 5
`define CTRB_MASK_OFS 16'hFFFF
`define CTRB_MASK_GAIN 16'h00FF
`define CTRB_RST_OFS 16'h0000
`define CTRB_RST_GAIN 16'h0000
`define CTRB_RD_UNMAPPED 32'h00000000
`define CTRB_STAT_FUSED 0
`define CTRB_STAT_SINGLE 1
`define CTRB_STAT_FGCAL 2
`define CTRB_STAT_APPLY 3

`endif

// file: ctrb_pkg.sv
// Purpose: Types for the converter trim register bank
// Assumes: Constants come from ctrb_consts.svh
// Notes:   State of each design module is one packed struct
`include "ctrb_consts.svh"

package ctrb_pkg;

    // ------------------------------------------------------------------
    // Fuse loader
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTRB_FL_WAIT = 2'b00,
        CTRB_FL_LOAD = 2'b01,
        CTRB_FL_DONE = 2'b10
    } ctrb_fuse_state_e;

    typedef struct packed {
        ctrb_fuse_state_e state;
        logic load;
    } ctrb_loader_s;

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    typedef logic [15:0] ctrb_word_t;

    typedef struct packed {
        ctrb_word_t [`CTRB_NUM_REGS-1:0] regs;
        logic [`CTRB_NUM_REGS-1:0] written;
        logic ack;
        logic [`CTRB_DATA_W-1:0] rdata;
        logic fused;
        logic [`CTRB_NUM_BANKS-1:0][`CTRB_GAIN_W-1:0] gain;
        logic [`CTRB_OFS_W-1:0] b_ofs;
        logic b_apply;
    } ctrb_bank_s;

endpackage

// file: ctrb_fuse_loader.sv
// Purpose: Issues one load pulse once fuse storage reports valid
// Assumes: fuse_ready is synchronous to clk_sys
// Notes:   Pulses once per reset; later fuse_ready changes are ignored
`timescale 1ns/10ps
`include "ctrb_consts.svh"

module ctrb_fuse_loader (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic fuse_ready,
    output logic fuse_load,
    output logic fuse_done
);

    ctrb_pkg::ctrb_loader_s r;
    ctrb_pkg::ctrb_loader_s r_nxt;

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    always_comb begin
        r_nxt = r;
        if (ce) begin
            r_nxt.load = 1'b0;
            case (r.state)
                ctrb_pkg::CTRB_FL_WAIT: begin
                    if (fuse_ready) begin
                        r_nxt.state = ctrb_pkg::CTRB_FL_LOAD;
                        r_nxt.load = 1'b1;
                    end
                end
                ctrb_pkg::CTRB_FL_LOAD: begin
                    r_nxt.state = ctrb_pkg::CTRB_FL_DONE;
                end
                ctrb_pkg::CTRB_FL_DONE: begin
                    r_nxt.state = ctrb_pkg::CTRB_FL_DONE;
                end
                default: begin
                    r_nxt.state = ctrb_pkg::CTRB_FL_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            r.state <= ctrb_pkg::CTRB_FL_WAIT;
            r.load <= 1'b0;
        end else begin
            r <= r_nxt;
        end
    end

    assign fuse_load = r.load;
    assign fuse_done = (r.state == ctrb_pkg::CTRB_FL_DONE);

endmodule // ctrb_fuse_loader

// file: ctrb_trim_regs.sv
// Purpose: Offset and fine-gain trim registers behind an Avalon-MM slave
// Assumes: All inputs synchronous to clk_sys; 32-bit bus, byte addresses
// Notes:   One wait state per access; fuse defaults load once after reset
`timescale 1ns/10ps
`include "ctrb_consts.svh"

// Function
// - 16-bit register at 0x34E, low 12 bits B offset, resets zero, RW.
// - B offset applied only on second input with foreground cal, any mode.
// - Dual-mode gain A bank 0 in bits 4:0 at 0x350, reset zero.
// - Dual-mode gain A bank 1 in bits 4:0 at 0x351, reset zero.
// - Dual-mode gain B bank 0 at 0x352; default comes from fuses.
// - Dual-mode gain B bank 1 at 0x353; bits 7:5 reserved but writable.
// - Single-mode gain A bank 0 at 0x354, replaces dual value there.
// - Single-mode gain A bank 1 in bits 4:0 at 0x355, reset zero.
// - Single-mode gain B bank 0 in bits 4:0 at 0x356, reset zero.
// - Single-mode gain B bank 1 in bits 4:0 at 0x357.
module ctrb_trim_regs (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [`CTRB_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`CTRB_DATA_W-1:0] avs_writedata,
    input wire logic [`CTRB_BE_W-1:0] avs_byteenable,
    output logic [`CTRB_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fuse_ready,
    input wire logic [15:0] fuse_b_offset,
    input wire logic [31:0] fuse_gain_dual,
    input wire logic [31:0] fuse_gain_single,
    input wire logic single_mode,
    input wire logic fg_cal_en,
    input wire logic b_on_second_analog_input,
    output logic [`CTRB_OFS_W-1:0] b_core_second_input_offset,
    output logic b_offset_apply,
    output logic [`CTRB_GAIN_W-1:0] gain_trim_a_bank0_field,
    output logic [`CTRB_GAIN_W-1:0] gain_trim_a_bank1_field,
    output logic [`CTRB_GAIN_W-1:0] gain_trim_b_bank0_dual,
    output logic [`CTRB_GAIN_W-1:0] gain_trim_b_bank1_field,
    output logic fuse_done
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ctrb_pkg::ctrb_bank_s r;
    ctrb_pkg::ctrb_bank_s r_nxt;
    logic fuse_load;
    logic req;
    logic commit_wr;
    logic take;
    logic [`CTRB_IDX_W-1:0] idx;
    logic aligned;
    logic [`CTRB_NUM_REGS-1:0] hit;
    logic stat_hit;
    ctrb_pkg::ctrb_word_t [`CTRB_NUM_REGS-1:0] wr_val;
    ctrb_pkg::ctrb_word_t [`CTRB_NUM_REGS-1:0] fuse_val;
    ctrb_pkg::ctrb_word_t rd_word;
    logic [`CTRB_DATA_W-1:0] stat_word;

    // ------------------------------------------------------------------
    // Register map helpers
    // ------------------------------------------------------------------
    function automatic logic [`CTRB_IDX_W-1:0] slot_index(input int s);
        logic [`CTRB_IDX_W-1:0] v;
        v = `CTRB_IDX_B_OFS;
        case (s)
            0: v = `CTRB_IDX_B_OFS;
            1: v = `CTRB_IDX_DUAL_A0;
            2: v = `CTRB_IDX_DUAL_A1;
            3: v = `CTRB_IDX_DUAL_B0;
            4: v = `CTRB_IDX_DUAL_B1;
            5: v = `CTRB_IDX_SNGL_A0;
            6: v = `CTRB_IDX_SNGL_A1;
            7: v = `CTRB_IDX_SNGL_B0;
            8: v = `CTRB_IDX_SNGL_B1;
            default: v = `CTRB_IDX_B_OFS;
        endcase
        return v;
    endfunction

    // Offset register keeps all 16 bits, gain registers their low byte
    function automatic ctrb_pkg::ctrb_word_t slot_mask(input int s);
        ctrb_pkg::ctrb_word_t m;
        m = `CTRB_MASK_GAIN;
        if (s == `CTRB_SLOT_B_OFS) begin
            m = `CTRB_MASK_OFS;
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Fuse default sequencing
    // ------------------------------------------------------------------
    ctrb_fuse_loader u_fuse_loader (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .fuse_ready(fuse_ready),
        .fuse_load(fuse_load),
        .fuse_done(fuse_done)
    );

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // First cycle of a request only captures read data; the second
    // cycle (ack set, clock enabled) releases waitrequest and commits.
    assign req = avs_read | avs_write;
    assign take = req & ~r.ack;
    assign commit_wr = avs_write & r.ack & ce;
    assign avs_waitrequest = req & ~(r.ack & ce);
    assign avs_readdata = r.rdata;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign idx = avs_address[`CTRB_ADDR_W-1:2];
    assign aligned = (avs_address[1:0] == 2'h0);
    assign stat_hit = aligned & (idx == `CTRB_IDX_STATUS);

    // ------------------------------------------------------------------
    // Per-register decode, write merge and fuse default
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CTRB_NUM_REGS; g = g + 1) begin : g_reg
            logic [7:0] lo;
            logic [7:0] hi;
            // Byte lanes 0 and 1 carry the register; upper lanes ignored
            assign lo = avs_byteenable[0] ? avs_writedata[7:0]
                                          : r.regs[g][7:0];
            assign hi = avs_byteenable[1] ? avs_writedata[15:8]
                                          : r.regs[g][15:8];
            assign hit[g] = aligned & (idx == slot_index(g));
            assign wr_val[g] = {hi, lo} & slot_mask(g);
            if (g == `CTRB_SLOT_B_OFS) begin : g_ofs
                assign fuse_val[g] = fuse_b_offset & slot_mask(g);
            end else if (g < `CTRB_SLOT_SNGL0) begin : g_dual
                assign fuse_val[g] = {8'h00,
                    fuse_gain_dual[(g-`CTRB_SLOT_DUAL0)*8 +: 8]};
            end else begin : g_sngl
                assign fuse_val[g] = {8'h00,
                    fuse_gain_single[(g-`CTRB_SLOT_SNGL0)*8 +: 8]};
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 16'h0000;
        for (int i = 0; i < `CTRB_NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_word = r.regs[i];
            end
        end
    end

    always_comb begin
        stat_word = `CTRB_RD_UNMAPPED;
        stat_word[`CTRB_STAT_FUSED] = r.fused;
        stat_word[`CTRB_STAT_SINGLE] = single_mode;
        stat_word[`CTRB_STAT_FGCAL] = fg_cal_en;
        stat_word[`CTRB_STAT_APPLY] = r.b_apply;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_nxt = r;
        if (ce) begin
            // Handshake: ack toggles on for exactly one clock-enabled cycle per request; it holds while ce is low
            r_nxt.ack = take;
            if (take) begin
                if (avs_read && |hit) begin
                    r_nxt.rdata = {16'h0000, rd_word};
                end else if (avs_read && stat_hit) begin
                    r_nxt.rdata = stat_word;
                end else begin
                    r_nxt.rdata = `CTRB_RD_UNMAPPED;
                end
            end

            // Fuse defaults fill only registers software has not written
            if (fuse_load) begin
                r_nxt.fused = 1'b1;
                for (int i = 0; i < `CTRB_NUM_REGS; i++) begin
                    if (!r.written[i]) begin
                        r_nxt.regs[i] = fuse_val[i];
                    end
                end
            end

            // A write in the load cycle wins over the fuse value
            if (commit_wr) begin
                for (int i = 0; i < `CTRB_NUM_REGS; i++) begin
                    if (hit[i]) begin
                        r_nxt.regs[i] = wr_val[i];
                        r_nxt.written[i] = 1'b1;
                    end
                end
            end

            // Offset drive: second input under foreground cal, any mode
            r_nxt.b_apply = fg_cal_en & b_on_second_analog_input;
            if (fg_cal_en && b_on_second_analog_input) begin
                r_nxt.b_ofs =
                    r.regs[`CTRB_SLOT_B_OFS][`CTRB_OFS_MSB:0];
            end else begin
                r_nxt.b_ofs = '0;
            end

            // Gain drive: single-mode set replaces the dual-mode set
            for (int b = 0; b < `CTRB_NUM_BANKS; b++) begin
                if (single_mode) begin
                    r_nxt.gain[b] = r.regs[`CTRB_SLOT_SNGL0 + b]
                        [`CTRB_GAIN_MSB:0];
                end else begin
                    r_nxt.gain[b] = r.regs[`CTRB_SLOT_DUAL0 + b]
                        [`CTRB_GAIN_MSB:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.regs[`CTRB_SLOT_B_OFS] <= `CTRB_RST_OFS;
            for (int i = 1; i < `CTRB_NUM_REGS; i++) begin
                r.regs[i] <= `CTRB_RST_GAIN;
            end
        end else begin
            r <= r_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign b_core_second_input_offset = r.b_ofs;
    assign b_offset_apply = r.b_apply;
    assign gain_trim_a_bank0_field = r.gain[0];
    assign gain_trim_a_bank1_field = r.gain[1];
    assign gain_trim_b_bank0_dual = r.gain[2];
    assign gain_trim_b_bank1_field = r.gain[3];

endmodule // ctrb_trim_regs

// file: ctrb_trim_regs_chk.sv
// Purpose: Concurrent checks on the trim register bank ports
// Assumes: Bound to ctrb_trim_regs; one clock domain
// Notes:   Sees the top module's ports only
`timescale 1ns/10ps
`include "ctrb_consts.svh"

module ctrb_trim_regs_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [`CTRB_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`CTRB_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic fg_cal_en,
    input wire logic b_on_second_analog_input,
    input wire logic [`CTRB_OFS_W-1:0] b_core_second_input_offset,
    input wire logic b_offset_apply,
    input wire logic fuse_done
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic req;
    logic al;
    logic is_gain;
    logic is_ofs;
    logic mapped;
    logic [`CTRB_IDX_W-1:0] idx;
    assign req = avs_read | avs_write;
    assign idx = avs_address[11:2];
    assign al = avs_address[1:0] == 2'h0;
    assign is_gain = al && idx >= `CTRB_IDX_DUAL_A0 && idx <= `CTRB_IDX_SNGL_B1;
    assign is_ofs = al && idx == `CTRB_IDX_B_OFS;
    assign mapped = is_gain || is_ofs || (al && idx == `CTRB_IDX_STATUS);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("request answered without a wait state");
    a_wait_one: assert property (req && avs_waitrequest && ce
        |=> !avs_waitrequest || !ce)
        else $error("request not answered after one wait state");
    a_ce_freeze: assert property (req && !ce |-> avs_waitrequest)
        else $error("request answered while clock enable low");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && !mapped |-> avs_readdata == 32'h00000000)
        else $error("unmapped read returned nonzero data");
    a_gain_width: assert property (avs_read && !avs_waitrequest
        && is_gain |-> avs_readdata[31:8] == 24'h000000)
        else $error("gain register read wider than eight bits");
    a_ofs_width: assert property (avs_read && !avs_waitrequest
        && is_ofs |-> avs_readdata[31:16] == 16'h0000)
        else $error("offset register read wider than sixteen bits");
    a_apply_set: assert property (ce && fg_cal_en
        && b_on_second_analog_input |=> b_offset_apply)
        else $error("offset not applied on second input with cal");
    a_apply_clr: assert property (ce && !fg_cal_en |=> !b_offset_apply)
        else $error("offset applied without foreground cal");
    a_ofs_gated: assert property (!b_offset_apply
        |-> b_core_second_input_offset == 12'h000)
        else $error("offset output nonzero while not applied");
    a_fuse_sticky: assert property (fuse_done |=> fuse_done)
        else $error("fuse done dropped without reset");
    cover property (avs_read && !avs_waitrequest);
    cover property (avs_write && !avs_waitrequest);
    cover property (b_offset_apply);
    cover property (req && !ce);
endmodule // ctrb_trim_regs_chk

bind ctrb_trim_regs ctrb_trim_regs_chk chk_u (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fg_cal_en(fg_cal_en),
    .b_on_second_analog_input(b_on_second_analog_input),
    .b_core_second_input_offset(b_core_second_input_offset),
    .b_offset_apply(b_offset_apply), .fuse_done(fuse_done)
);

// file: ctrb_trim_regs_tb.sv
// Purpose: Self-checking bench for the trim register bank
// Assumes: One wait state per access; fuse load after fuse_ready
// Notes:   Random data from a bench LFSR seeded with 75
`timescale 1ns/10ps
`include "ctrb_consts.svh"

module ctrb_trim_regs_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [`CTRB_ADDR_W-1:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [`CTRB_DATA_W-1:0] avs_writedata = 32'h00000000;
    logic [`CTRB_BE_W-1:0] avs_byteenable = 4'hF;
    logic [`CTRB_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic fuse_ready = 1'b0;
    logic [15:0] fuse_b_offset = 16'h0000;
    logic [31:0] fuse_gain_dual = 32'h00000000;
    logic [31:0] fuse_gain_single = 32'h00000000;
    logic single_mode = 1'b0;
    logic fg_cal_en = 1'b0;
    logic b_on_second_analog_input = 1'b0;
    logic [`CTRB_OFS_W-1:0] b_ofs;
    logic b_apply;
    logic [3:0][`CTRB_GAIN_W-1:0] g_out;
    logic fuse_done;
    logic [15:0] lfsr = 16'h004B;
    logic [15:0] mdl [9];
    logic [15:0] v;
    logic [31:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;

    always #2.5 clk_sys = ~clk_sys;

    ctrb_trim_regs dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fuse_ready(fuse_ready), .fuse_b_offset(fuse_b_offset),
        .fuse_gain_dual(fuse_gain_dual), .fuse_gain_single(fuse_gain_single),
        .single_mode(single_mode), .fg_cal_en(fg_cal_en),
        .b_on_second_analog_input(b_on_second_analog_input),
        .b_core_second_input_offset(b_ofs), .b_offset_apply(b_apply),
        .gain_trim_a_bank0_field(g_out[0]), .gain_trim_a_bank1_field(g_out[1]),
        .gain_trim_b_bank0_dual(g_out[2]), .gain_trim_b_bank1_field(g_out[3]),
        .fuse_done(fuse_done)
    );

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [11:0] reg_addr(input int i);
        return (i == 0) ? 12'hD38 : 12'hD3C + 12'(4 * i);
    endfunction
    function automatic logic [15:0] reg_mask(input int i);
        return (i == 0) ? 16'hFFFF : 16'h00FF;
    endfunction
    function automatic logic [15:0] fuse_val(input int i);
        logic [31:0] w;
        w = (i < 5) ? fuse_gain_dual : fuse_gain_single;
        return (i == 0) ? fuse_b_offset : {8'h00, w[8 * ((i - 1) % 4) +: 8]};
    endfunction

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %08h expected %08h",
                $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        // Request stands until waitrequest is sampled low at a rising edge
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        finish_test;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, reg_addr(i), 32'h0, 4'hF);
            check(rd, 32'h0);
        end
        @(posedge clk_sys);
        lfsr = lfsr_next(lfsr);
        fuse_b_offset <= lfsr;
        fuse_gain_dual <= {lfsr_next(lfsr), lfsr ^ 16'h5A3C};
        fuse_gain_single <= {lfsr, lfsr_next(lfsr) ^ 16'hC3A5};
        fuse_ready <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({31'h0, fuse_done}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            mdl[i] = fuse_val(i);
            bus(1'b0, reg_addr(i), 32'h0, 4'hF);
            check(rd, {16'h0, mdl[i]});
        end
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            v = (i == 4) ? 16'h00E0 : lfsr;
            mdl[i] = v & reg_mask(i);
            bus(1'b1, reg_addr(i), {~lfsr, v}, 4'hF);
        end
        bus(1'b1, reg_addr(0), 32'h0000A55A, 4'h2);
        mdl[0][15:8] = 8'hA5;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, reg_addr(i), 32'h0, 4'hF);
            check(rd, {16'h0, mdl[i]});
        end
        bus(1'b1, 12'hD3C, 32'h0000FFFF, 4'hF);
        bus(1'b0, 12'hD3C, 32'h0, 4'hF);
        check(rd, 32'h0);
        bus(1'b0, reg_addr(1) + 12'h1, 32'h0, 4'hF);
        check(rd, 32'h0);
        @(posedge clk_sys);
        ce <= 1'b0;
        fork
            begin
                repeat (3) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join_none
        bus(1'b0, reg_addr(0), 32'h0, 4'hF);
        check(rd, {16'h0, mdl[0]});
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge clk_sys);
                single_mode <= m[0];
                fg_cal_en <= c[0];
                b_on_second_analog_input <= c[1];
                repeat (3) @(posedge clk_sys);
                check({31'h0, b_apply}, {31'h0, c == 3});
                check({20'h0, b_ofs}, (c == 3) ? {20'h0, mdl[0][11:0]} : 32'h0);
                for (int k = 0; k < 4; k++)
                    check({27'h0, g_out[k]}, {27'h0, mdl[(m ? 5 : 1) + k][4:0]});
                bus(1'b0, 12'hFC0, 32'h0, 4'hF);
                check(rd, {28'h0, c == 3, c[0], m[0], 1'b1});
            end
        end
        // Mid-run reset: a write before the fuse load keeps its value
        @(posedge clk_sys);
        nrst <= 1'b0;
        fuse_ready <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b1, reg_addr(3), 32'h0000005A, 4'hF);
        check({31'h0, fuse_done}, 32'h0);
        @(posedge clk_sys);
        fuse_ready <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({31'h0, fuse_done}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            mdl[i] = (i == 3) ? 16'h005A : fuse_val(i);
            bus(1'b0, reg_addr(i), 32'h0, 4'hF);
            check(rd, {16'h0, mdl[i]});
        end
        finish_test;
    end
endmodule // ctrb_trim_regs_tb
